// ### shared/pciu_pkg.sv
// Package for the pin change interrupt unit: register map, field layouts, carriers
package pciu_pkg;

  // ----------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ----------------------------------------------------------------
  localparam logic [9:0] IDX_ENABLE_CONTROL = 10'h068;
  localparam logic [9:0] IDX_MASK_GROUP0 = 10'h06b;
  localparam logic [9:0] IDX_MASK_GROUP1 = 10'h06c;
  localparam logic [9:0] IDX_MASK_GROUP2 = 10'h06d;
  localparam logic [9:0] IDX_MASK_GROUP3 = 10'h073;
  localparam logic [9:0] IDX_FLAG_STATUS = 10'h074;
  localparam logic [9:0] IDX_STATUS_WORD = 10'h075;

  // ----------------------------------------------------------------
  // Field layout and reset values
  // ----------------------------------------------------------------
  localparam int NUM_GROUPS = 4;
  localparam int GROUP_PINS = 8;
  localparam int GLOBAL_ENABLE_BIT = 7;
  localparam logic [7:0] RESET_MASK = 8'h00;
  localparam logic [3:0] RESET_GROUP_BITS = 4'h0;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Bus carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic awvalid;
    logic [11:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [11:0] araddr;
    logic rready;
  } pciu_axi_req_type;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } pciu_axi_rsp_type;

endpackage

// ### verilog/pciu_top.sv
// Pin change interrupt unit: 32 pins in four groups behind an AXI4-Lite slave
//
// Chosen here: the AXI4-Lite register port.
`timescale 1ns/100ps

module pciu_top (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_reset,
  // Register bus
  input wire pciu_pkg::pciu_axi_req_type i_axi,
  output pciu_pkg::pciu_axi_rsp_type o_axi,
  // Pins and processor side
  input wire logic [31:0] i_change_sense_pins,
  input wire logic [3:0] i_vector_ack,
  output logic [3:0] o_group_vector_req,
  output logic o_irq,
  output logic o_wake
);
  import pciu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    pciu_axi_rsp_type axi;
    logic aw_held;
    logic w_held;
    logic [9:0] wr_index;
    logic [7:0] wr_byte;
    logic wr_lane0;
    logic [3:0][7:0] mask;
    logic [3:0] enable;
    logic global_enable;
    logic [3:0] flags;
    logic [31:0] prev_pins;
    logic [3:0] vector_req;
    logic irq;
    logic wake;
  } pciu_state_type;

  pciu_state_type state;
  pciu_state_type next_state;

  logic [3:0] hit;
  logic [3:0] sw_clear;
  logic wr_fire;
  logic wr_mapped;
  logic [9:0] rd_index;
  logic [7:0] rd_byte;
  logic rd_mapped;
  logic [31:0] changed;
  logic [3:0][7:0] group_changed;
  logic [3:0][7:0] group_armed;
  logic [3:0] group_clear;
  logic [3:0] group_request;
  logic aw_take;
  logic w_take;
  logic b_release;
  logic ar_take;
  logic r_release;
  logic wr_commit;
  logic wr_sel_enable;
  logic [3:0] wr_sel_mask;
  logic wr_sel_flags;
  logic wr_sel_status;

  // ----------------------------------------------------------------
  // Change detection
  // ----------------------------------------------------------------
  // Pins arrive synchronous to the clock, so one previous sample suffices.
  // The change is seen combinationally, so a sleeping core is woken by the
  // registered wake output without any I/O clock gating in between.
  assign changed = i_change_sense_pins ^ state.prev_pins;
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_group
    // Only pins whose mask bit is one, in an enabled group, count
    assign group_changed[g] = changed[g*GROUP_PINS +: GROUP_PINS];
    assign group_armed[g] = state.mask[g]
                            & {GROUP_PINS{state.enable[g]}};
    assign hit[g] = |(group_changed[g] & group_armed[g]);
    // Handler entry and a software clear form one clear term per group
    assign group_clear[g] = sw_clear[g] | i_vector_ack[g];
    // The request looks at the registered flag, so it trails it by one edge
    assign group_request[g] = state.flags[g] & state.enable[g]
                              & state.global_enable;
  end

  // ----------------------------------------------------------------
  // Bus handshake events
  // ----------------------------------------------------------------
  // Each channel moves one item where its valid and its ready meet
  always_comb begin
    aw_take = i_axi.awvalid && state.axi.awready;
    w_take = i_axi.wvalid && state.axi.wready;
    b_release = state.axi.bvalid && i_axi.bready;
    ar_take = i_axi.arvalid && state.axi.arready;
    r_release = state.axi.rvalid && i_axi.rready;
    // Both halves held and no answer pending: the write lands now
    wr_fire = state.aw_held && state.w_held && !state.axi.bvalid;
  end

  // ----------------------------------------------------------------
  // Register write decode
  // ----------------------------------------------------------------
  // Selects fire only with lane 0 on, so a write without it is answered
  // OKAY at a mapped index, SLVERR elsewhere, and changes nothing
  always_comb begin
    wr_mapped = 1'b1;
    wr_commit = wr_fire && state.wr_lane0;
    wr_sel_enable = 1'b0;
    wr_sel_mask = 4'h0;
    wr_sel_flags = 1'b0;
    wr_sel_status = 1'b0;
    unique case (state.wr_index)
      IDX_ENABLE_CONTROL: wr_sel_enable = wr_commit;
      IDX_MASK_GROUP0: wr_sel_mask[0] = wr_commit;
      IDX_MASK_GROUP1: wr_sel_mask[1] = wr_commit;
      IDX_MASK_GROUP2: wr_sel_mask[2] = wr_commit;
      IDX_MASK_GROUP3: wr_sel_mask[3] = wr_commit;
      IDX_FLAG_STATUS: wr_sel_flags = wr_commit;
      IDX_STATUS_WORD: wr_sel_status = wr_commit;
      default: wr_mapped = 1'b0;
    endcase
    // Set bits clear their flag; zero bits leave it alone
    sw_clear = wr_sel_flags ? state.wr_byte[3:0] : 4'h0;
  end

  // ----------------------------------------------------------------
  // Register read decode
  // ----------------------------------------------------------------
  always_comb begin
    rd_index = i_axi.araddr[11:2];
    rd_mapped = 1'b1;
    rd_byte = 8'h00;
    unique case (rd_index)
      IDX_ENABLE_CONTROL: rd_byte = {4'h0, state.enable};
      IDX_MASK_GROUP0: rd_byte = state.mask[0];
      IDX_MASK_GROUP1: rd_byte = state.mask[1];
      IDX_MASK_GROUP2: rd_byte = state.mask[2];
      IDX_MASK_GROUP3: rd_byte = state.mask[3];
      IDX_FLAG_STATUS: rd_byte = {4'h0, state.flags};
      IDX_STATUS_WORD: rd_byte = {state.global_enable, 7'h00};
      default: rd_mapped = 1'b0;
    endcase
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_state = state;
    next_state.prev_pins = i_change_sense_pins;

    // Write address and data are taken independently, in either order
    if (aw_take) begin
      next_state.aw_held = 1'b1;
      next_state.wr_index = i_axi.awaddr[11:2];
      next_state.axi.awready = 1'b0;
    end
    if (w_take) begin
      next_state.w_held = 1'b1;
      next_state.wr_byte = i_axi.wdata[7:0];
      next_state.wr_lane0 = i_axi.wstrb[0];
      next_state.axi.wready = 1'b0;
    end
    if (wr_fire) begin
      next_state.aw_held = 1'b0;
      next_state.w_held = 1'b0;
      next_state.axi.bvalid = 1'b1;
      next_state.axi.bresp = wr_mapped ? RESP_OKAY : RESP_SLVERR;
      if (wr_sel_enable) begin
        next_state.enable = state.wr_byte[3:0];
      end
      for (int g = 0; g < NUM_GROUPS; g++) begin
        if (wr_sel_mask[g]) begin
          next_state.mask[g] = state.wr_byte;
        end
      end
      if (wr_sel_status) begin
        next_state.global_enable = state.wr_byte[GLOBAL_ENABLE_BIT];
      end
    end
    if (b_release) begin
      next_state.axi.bvalid = 1'b0;
      next_state.axi.awready = 1'b1;
      next_state.axi.wready = 1'b1;
    end

    // One read at a time: address taken, data answered the next cycle
    if (ar_take) begin
      next_state.axi.arready = 1'b0;
      next_state.axi.rvalid = 1'b1;
      next_state.axi.rdata = {24'h000000, rd_byte};
      next_state.axi.rresp = rd_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    if (r_release) begin
      next_state.axi.rvalid = 1'b0;
      next_state.axi.arready = 1'b1;
    end

    // A new change wins over a clear in the same cycle; repeated changes
    // only keep the single flag set, so one request stays pending
    next_state.flags = (state.flags & ~group_clear) | hit;

    // Requests follow the flags one cycle later, gated by both enables
    next_state.vector_req = group_request;
    next_state.irq = |next_state.vector_req;
    next_state.wake = |hit;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      state <= '0;
      state.mask <= {NUM_GROUPS{RESET_MASK}};
      state.enable <= RESET_GROUP_BITS;
      state.flags <= RESET_GROUP_BITS;
      state.axi.awready <= 1'b1;
      state.axi.wready <= 1'b1;
      state.axi.arready <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_axi = state.axi;
  assign o_group_vector_req = state.vector_req;
  assign o_irq = state.irq;
  assign o_wake = state.wake;

endmodule // pciu_top

// ### verif/pciu_checker_assertions.sv
// Port checker for the pin change interrupt unit
`timescale 1ns/100ps
module pciu_checker (
  // Watched ports
  input wire logic i_mclk,
  input wire logic i_reset,
  input wire pciu_pkg::pciu_axi_req_type i_axi,
  input wire pciu_pkg::pciu_axi_rsp_type o_axi,
  input wire logic [31:0] i_change_sense_pins,
  input wire logic [3:0] i_vector_ack,
  input wire logic [3:0] o_group_vector_req,
  input wire logic o_irq,
  input wire logic o_wake
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  AST_IRQ_OR: assert property (o_irq == |o_group_vector_req)
    else $error("irq differs from requests");
  AST_WAKE_CAUSE: assert property (o_wake |-> $past(i_change_sense_pins) !=
    $past(i_change_sense_pins, 2)) else $error("wake without pin change");
  AST_WAKE_PULSE: assert property (o_wake && $stable(i_change_sense_pins) |=> !o_wake)
    else $error("wake too long");
  AST_RESET_CLEAR: assert property ($fell(i_reset) |-> !o_irq && !o_wake &&
    o_group_vector_req == 4'h0) else $error("output set after reset");
  // Only group 0 is checked, and only while its pins are quiet, since a fresh change wins over the clear
  AST_ACK_CLEAR: assert property (i_vector_ack[0] && $stable(i_change_sense_pins[7:0])
    |-> ##2 !o_group_vector_req[0]) else $error("ack kept request");
  AST_READ_LAT: assert property (i_axi.arvalid && o_axi.arready |=> o_axi.rvalid &&
    o_axi.rdata[31:8] == 24'h0) else $error("read answer wrong");
  AST_ERR_DATA: assert property (o_axi.rvalid && o_axi.rresp != 2'h0 |->
    o_axi.rdata == 32'h0) else $error("refused read with data");
  AST_WRITE_LAT: assert property (i_axi.awvalid && o_axi.awready && i_axi.wvalid &&
    o_axi.wready |-> ##2 o_axi.bvalid) else $error("write answer late");
endmodule // pciu_checker

// ### verif/pciu_pins.sv
// Model of the outside circuitry that toggles the sensed pins
`timescale 1ns/100ps
module pciu_pins (
  // Clock and toggle request
  input wire logic i_mclk,
  input wire logic [31:0] i_flip,
  // Pin levels
  output logic [31:0] o_pins = 32'h0
);
  // Levels move just after an edge, as a synchronised input would
  always @(posedge i_mclk) begin
    o_pins <= o_pins ^ i_flip;
  end
endmodule // pciu_pins

// ### verif/test_pin_change_interrupt_unit.sv
// Testbench for the pin change interrupt unit
`timescale 1ns/100ps
module test_pin_change_interrupt_unit;
  import pciu_pkg::*;
  logic i_mclk = 1'b0;
  logic i_reset = 1'b1;
  pciu_axi_req_type axi = '0;
  pciu_axi_rsp_type o_axi;
  logic [31:0] flip = 32'h0;
  logic [31:0] pins;
  logic [3:0] ack = 4'h0;
  logic [3:0] req;
  logic irq;
  logic wake;
  int bad_count = 0;
  int check_count = 0;
  logic [9:0] mix [4] = '{IDX_MASK_GROUP0, IDX_MASK_GROUP1, IDX_MASK_GROUP2, IDX_MASK_GROUP3};
  always #10 i_mclk = ~i_mclk;
  pciu_pins u_pins (.i_mclk(i_mclk), .i_flip(flip), .o_pins(pins));
  pciu_top DUT (.i_mclk(i_mclk), .i_reset(i_reset), .i_axi(axi), .o_axi(o_axi),
    .i_change_sense_pins(pins), .i_vector_ack(ack), .o_group_vector_req(req),
    .o_irq(irq), .o_wake(wake));
  task automatic complete_run;
    if (bad_count == 0 && check_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic wr(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] r = RESP_OKAY,
    input logic [3:0] s = 4'hf);
    axi.awaddr <= {ix, 2'h0};
    axi.wdata <= {24'h0, d};
    axi.wstrb <= s;
    axi.awvalid <= 1'b1;
    axi.wvalid <= 1'b1;
    axi.bready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge i_mclk);
      if (o_axi.awready) axi.awvalid <= 1'b0;
      if (o_axi.wready) axi.wvalid <= 1'b0;
      if (o_axi.bvalid) begin
        axi.bready <= 1'b0;
        chk(32'(o_axi.bresp), 32'(r));
        @(posedge i_mclk);
        return;
      end
    end
    bad_count++;
    complete_run;
  endtask
  task automatic rd(input logic [9:0] ix, input logic [7:0] d, input logic [1:0] r = RESP_OKAY);
    axi.araddr <= {ix, 2'h0};
    axi.arvalid <= 1'b1;
    axi.rready <= 1'b1;
    for (int n = 0; n < 40; n++) begin
      @(posedge i_mclk);
      if (o_axi.arready) axi.arvalid <= 1'b0;
      if (o_axi.rvalid) begin
        axi.rready <= 1'b0;
        chk(o_axi.rdata, {24'h0, d});
        chk(32'(o_axi.rresp), 32'(r));
        @(posedge i_mclk);
        return;
      end
    end
    bad_count++;
    complete_run;
  endtask
  // Flag lands one edge after the pins move, the request one edge later
  // The wake pulse stands for the one cycle after the flag edge
  task automatic flp(input logic [31:0] v, input logic w);
    flip <= v;
    @(posedge i_mclk);
    flip <= 32'h0;
    repeat (2) @(posedge i_mclk);
    chk(32'(wake), 32'(w));
    @(posedge i_mclk);
  endtask
  task automatic s_reset;
    foreach (mix[i]) rd(mix[i], RESET_MASK);
    rd(IDX_FLAG_STATUS, {4'h0, RESET_GROUP_BITS});
    rd(IDX_ENABLE_CONTROL, {4'h0, RESET_GROUP_BITS});
    rd(IDX_STATUS_WORD, 8'h00);
    wr(IDX_ENABLE_CONTROL, 8'hff);
    rd(IDX_ENABLE_CONTROL, 8'h0f);
    // Lane 0 off: the write is answered but must not land
    wr(IDX_ENABLE_CONTROL, 8'h00, RESP_OKAY, 4'he);
    rd(IDX_ENABLE_CONTROL, 8'h0f);
    wr(10'h3ff, 8'h01, RESP_SLVERR);
    rd(10'h3ff, 8'h00, RESP_SLVERR);
  endtask
  task automatic s_gate;
    foreach (mix[i]) wr(mix[i], 8'hff);
    wr(IDX_ENABLE_CONTROL, 8'h0f);
    flp(32'hffffffff, 1'b1);
    chk(32'(req), 32'h0);
    rd(IDX_FLAG_STATUS, 8'h0f);
    wr(IDX_FLAG_STATUS, 8'h0f);
    wr(IDX_ENABLE_CONTROL, 8'h00);
    flp(32'hffffffff, 1'b0);
    rd(IDX_FLAG_STATUS, 8'h00);
    wr(IDX_STATUS_WORD, 8'h80);
  endtask
  task automatic s_group(input int g);
    logic [3:0] b;
    b = 4'h1 << g;
    wr(mix[g], 8'h81);
    wr(IDX_ENABLE_CONTROL, {4'h0, b});
    flp(32'h2 << (8 * g), 1'b0);
    chk(32'(req), 32'h0);
    flp(32'h81 << (8 * g), 1'b1);
    chk(32'(req), 32'(b));
    chk(32'(irq), 32'h1);
    wr(IDX_FLAG_STATUS, 8'h00);
    rd(IDX_FLAG_STATUS, {4'h0, b});
    ack <= b;
    @(posedge i_mclk);
    ack <= 4'h0;
    rd(IDX_FLAG_STATUS, 8'h00);
    chk(32'(req), 32'h0);
    flp(32'h1 << (8 * g), 1'b1);
    wr(IDX_FLAG_STATUS, {4'h0, b});
    rd(IDX_FLAG_STATUS, 8'h00);
    rd(mix[g], 8'h81);
  endtask
  // Reset again in mid-run, with a flag and a request standing
  task automatic s_rerun;
    wr(mix[0], 8'hff);
    wr(IDX_ENABLE_CONTROL, 8'h01);
    flp(32'h1, 1'b1);
    chk(32'(req), 32'h1);
    i_reset <= 1'b1;
    repeat (2) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    chk(32'(req), 32'h0);
    chk(32'(irq), 32'h0);
    rd(IDX_FLAG_STATUS, {4'h0, RESET_GROUP_BITS});
    rd(mix[0], RESET_MASK);
    rd(IDX_ENABLE_CONTROL, {4'h0, RESET_GROUP_BITS});
    rd(IDX_STATUS_WORD, 8'h00);
  endtask
  initial begin
    repeat (16) @(posedge i_mclk);
    i_reset <= 1'b0;
    @(posedge i_mclk);
    s_reset();
    s_gate();
    for (int g = 0; g < 4; g++) s_group(g);
    s_rerun();
    complete_run();
  end
endmodule // test_pin_change_interrupt_unit
bind pciu_top pciu_checker u_chk (.i_mclk(i_mclk), .i_reset(i_reset), .i_axi(i_axi),
  .o_axi(o_axi), .i_change_sense_pins(i_change_sense_pins), .i_vector_ack(i_vector_ack),
  .o_group_vector_req(o_group_vector_req), .o_irq(o_irq), .o_wake(o_wake));
